/* File: design/pts_telemetry_status.sv */
/*
 * Read-only status and telemetry registers behind the serial management
 * command port: vendor fault byte, six telemetry words, read sequencer,
 * communication error flags and the thermal monitor latch-off.
 * Assumes a transaction layer that hands over one decoded command at a
 * time and sends the returned bytes on the bus in the order given.
 */
// What this block does
// - Fault byte at 80h, zero after reset
// - Bit 6: sharing phase failed on rail
// - Bit 4: inter-device bus error seen
// - Bit 3: external clock sync lost
// - Bit 2: fault spread through fault group
// - Bit 1: power stage pulled monitor high
// - Bit 0: enable-pin fault line shutdown
// - Input voltage word at 88h
// - Telemetry reads carry exactly two bytes
// - Linear-11 value is mantissa times two^exponent
// - Output voltage unsigned, exponent -13, at 8Bh
// - Current at 8Ch, none while unregulated
// - Internal temperature Linear-11 at 8Dh
// - Pin temperature (V-0.6)/0.008 at 8Fh
// - Monitor above 2.5 V latches shutdown
// - Duty cycle while enabled at 94h
// - Writes to these registers flag error
`timescale 1ns/1ps
`include "pts_regs.svh"
module pts_telemetry_status #(
    parameter int SAMPLE_CYCLES = `PTS_SAMPLE_CYCLES
) (
    input  wire logic               ref_clk,
    input  wire logic               arst_n,
    input  wire pts_pkg::pts_cmd_t  cmd,
    input  wire logic               clearFaults,
    input  wire pts_pkg::pts_fault_t faultPins,
    input  wire pts_pkg::pts_cfg_t  cfg,
    input  wire pts_pkg::pts_meas_t meas,
    output logic                    busy,
    output logic                    rspValid,
    output logic [7:0]              rspByte,
    output logic                    rspLast,
    output logic [7:0]              cmlStatus,
    output logic [7:0]              vendorStatus,
    output logic                    shutdownLatched
);
    import pts_pkg::*;

    // Refuse a refresh period the counter cannot hold
    if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 65535) begin : gSampleCheck
        $error("pts_telemetry_status: SAMPLE_CYCLES out of range");
    end

    // Synchronised fault levels
    pts_fault_t faultSync;            // Pin levels after two flops
    logic [7:0] vendorSet;            // Fault bits raised this cycle
    logic [7:0] vendorQ;              // Sticky fault byte
    logic [7:0] vendorD;              // Next fault byte
    logic       shutdownQ;            // Thermal latch-off

    // Telemetry shadow registers
    logic [15:0] vinW;                // Packed input voltage
    logic [15:0] ioutW;               // Packed output current
    logic [15:0] tintW;               // Packed internal temperature
    logic [15:0] textW;               // Packed pin temperature
    logic [15:0] dutyW;               // Packed duty cycle
    logic signed [15:0] tmonDelta;    // Pin voltage above 0.6 V, mV
    logic [15:0] vinQ;                // Held input voltage
    logic [15:0] voutQ;               // Held output voltage
    logic [15:0] ioutQ;               // Held output current
    logic [15:0] tintQ;               // Held internal temperature
    logic [15:0] textQ;               // Held pin temperature
    logic [15:0] dutyQ;               // Held duty cycle

    // Refresh divider
    logic [15:0] divQ;                // Cycles since last refresh
    logic        samplePulse;         // One-cycle refresh enable

    // Command decode and read-out
    pts_state_t  stateQ;              // Sequencer state
    pts_state_t  stateD;              // Next sequencer state
    logic        cmdTaken;            // Command accepted this cycle
    logic [1:0]  codeLen;             // Bytes of the code, zero if unknown
    logic        lenBad;              // Host asked the wrong count
    logic        writeBad;            // Host tried a write
    logic [15:0] readWord;            // Selected register contents
    logic [15:0] wordQ;               // Word being sent
    logic        twoByteQ;            // Word has a high byte
    logic [7:0]  cmlQ;                // Communication error flags
    logic [7:0]  cmlSet;              // Error bits raised this cycle
    logic        rspValidQ;           // Byte strobe
    logic [7:0]  rspByteQ;            // Byte out
    logic        rspLastQ;            // Final byte marker
    logic        busyQ;               // Sequencer not idle

    // Length of each known command, zero when unsupported
    function automatic logic [1:0] code_len(input logic [7:0] c);
        case (c)
            `PTS_CMD_VENDOR_STATUS: return `PTS_LEN_STATUS;
            `PTS_CMD_VIN,
            `PTS_CMD_VOUT,
            `PTS_CMD_IOUT,
            `PTS_CMD_TEMP_INT,
            `PTS_CMD_TEMP_EXT,
            `PTS_CMD_DUTY:          return `PTS_LEN_TELEMETRY;
            default:                return 2'd0;
        endcase
    endfunction

    // Fault pins cross into the clock domain
    pts_sync #(
        .WIDTH ($bits(pts_fault_t))
    ) uFaultSync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .din     (faultPins),
        .dout    (faultSync)
    );

    // Fault bits raised by synchronised conditions
    assign vendorSet[7] = 1'b0;
    assign vendorSet[`PTS_BIT_PHASE] = faultSync.phaseFail & cfg.sharedRail;
    assign vendorSet[5] = 1'b0;
    assign vendorSet[`PTS_BIT_DDC] = faultSync.ddcError;
    assign vendorSet[`PTS_BIT_SYNC] = faultSync.syncLost;
    assign vendorSet[`PTS_BIT_GROUP] = faultSync.groupFault;
    assign vendorSet[`PTS_BIT_STAGE] = faultSync.stageOverLimit;
    assign vendorSet[`PTS_BIT_FAULT_BUS] = faultSync.enableFaultBus & cfg.enableIsBus;

    // Clear drops old bits but a fresh event survives
    assign vendorD = (clearFaults ? vendorSet : (vendorQ | vendorSet)) & `PTS_VENDOR_MASK;

    // Sticky fault byte
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            vendorQ <= `PTS_VENDOR_RESET;
        end else begin
            vendorQ <= vendorD;
        end
    end

    // Thermal monitor over limit latches the converter off until reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdownQ <= 1'b0;
        end else if (cfg.tmonOtEnable && faultSync.stageOverLimit) begin
            shutdownQ <= 1'b1;
        end
    end

    // Pin temperature: (mV - 600) / 8 gives degrees
    assign tmonDelta = meas.tmonMv - `PTS_THERMAL_MONITOR_PIN_OFFSET_MV;

    // Linear-11 packers
    pts_linear11 #(.EXP(`PTS_VIN_EXP)) uPackVin (
        .raw  (meas.vin),
        .word (vinW)
    );
    pts_linear11 #(.EXP(`PTS_IOUT_EXP)) uPackIout (
        .raw  (meas.iout),
        .word (ioutW)
    );
    pts_linear11 #(.EXP(`PTS_TINT_EXP)) uPackTint (
        .raw  (meas.tint),
        .word (tintW)
    );
    pts_linear11 #(.EXP(`PTS_THERMAL_MONITOR_PIN_EXP)) uPackText (
        .raw  (tmonDelta),
        .word (textW)
    );
    pts_linear11 #(.EXP(`PTS_DUTY_EXP)) uPackDuty (
        .raw  (meas.duty),
        .word (dutyW)
    );

    // Refresh divider pulse
    assign samplePulse = (divQ == 16'(SAMPLE_CYCLES - 1));

    // Divider counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            divQ <= 16'h0000;
        end else begin
            divQ <= samplePulse ? 16'h0000 : divQ + 16'h0001;
        end
    end

    // Telemetry capture on each refresh
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            vinQ  <= 16'h0000;
            voutQ <= 16'h0000;
            ioutQ <= 16'h0000;
            tintQ <= 16'h0000;
            textQ <= 16'h0000;
            dutyQ <= 16'h0000;
        end else if (samplePulse) begin
            vinQ  <= vinW;
            voutQ <= meas.vout;
            ioutQ <= meas.pwmActive ? ioutW : 16'h0000;
            tintQ <= tintW;
            textQ <= textW;
            dutyQ <= meas.enabled ? dutyW : 16'h0000;
        end
    end

    // Command checks
    assign cmdTaken = cmd.valid & (stateQ == PTS_IDLE);
    assign codeLen  = code_len(cmd.code);
    assign writeBad = cmd.write & (codeLen != 2'd0);
    assign lenBad   = ~cmd.write & (codeLen != 2'd0) & (cmd.len != codeLen);

    // Error bits raised by the accepted command
    assign cmlSet[`PTS_CML_BIT_INVALID] = cmdTaken & (codeLen == 2'd0);
    assign cmlSet[6:2] = 5'h00;
    assign cmlSet[`PTS_CML_BIT_ACCESS] = cmdTaken & (writeBad | lenBad);
    assign cmlSet[0] = 1'b0;

    // Register selection by command code
    assign readWord = (cmd.code == `PTS_CMD_VENDOR_STATUS) ? {8'h00, vendorQ} :
                      (cmd.code == `PTS_CMD_VIN)           ? vinQ  :
                      (cmd.code == `PTS_CMD_VOUT)          ? voutQ :
                      (cmd.code == `PTS_CMD_IOUT)          ? ioutQ :
                      (cmd.code == `PTS_CMD_TEMP_INT)      ? tintQ :
                      (cmd.code == `PTS_CMD_TEMP_EXT)      ? textQ :
                      (cmd.code == `PTS_CMD_DUTY)          ? dutyQ : 16'h0000;

    // Communication error flags, set wins over clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmlQ <= `PTS_CML_RESET;
        end else begin
            cmlQ <= clearFaults ? cmlSet : (cmlQ | cmlSet);
        end
    end

    // Next state of the read-out sequencer
    always_comb begin
        stateD = stateQ;
        case (stateQ)
            PTS_IDLE: begin
                // Only a clean read starts a reply
                if (cmdTaken && !cmd.write && codeLen != 2'd0 && !lenBad) begin
                    stateD = PTS_LOW;
                end
            end
            PTS_LOW: begin
                // Low byte first, then high if present
                stateD = twoByteQ ? PTS_HIGH : PTS_IDLE;
            end
            PTS_HIGH: begin
                stateD = PTS_IDLE;
            end
            default: begin
                stateD = PTS_IDLE;
            end
        endcase
    end

    // Sequencer state and busy flag
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stateQ <= PTS_IDLE;
            busyQ  <= 1'b0;
        end else begin
            stateQ <= stateD;
            busyQ  <= (stateD != PTS_IDLE);
        end
    end

    // Word held for the reply
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wordQ    <= 16'h0000;
            twoByteQ <= 1'b0;
        end else if (stateQ == PTS_IDLE && stateD == PTS_LOW) begin
            wordQ    <= readWord;
            twoByteQ <= (codeLen == `PTS_LEN_TELEMETRY);
        end
    end

    // Byte stream, low byte first
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rspValidQ <= 1'b0;
            rspByteQ  <= 8'h00;
            rspLastQ  <= 1'b0;
        end else begin
            rspValidQ <= (stateQ != PTS_IDLE);
            rspByteQ  <= (stateQ == PTS_HIGH) ? wordQ[15:8] : wordQ[7:0];
            rspLastQ  <= (stateQ == PTS_HIGH) || (stateQ == PTS_LOW && !twoByteQ);
        end
    end

    // Outputs straight from flops
    assign busy            = busyQ;
    assign rspValid        = rspValidQ;
    assign rspByte         = rspByteQ;
    assign rspLast         = rspLastQ;
    assign cmlStatus       = cmlQ;
    assign vendorStatus    = vendorQ;
    assign shutdownLatched = shutdownQ;

endmodule

/* File: design/pts_regs.svh */
/*
 * Command codes, bit positions, reset values and timing counts of the
 * telemetry and vendor fault status block.
 * Assumes it is included by bare name from the modules that use it.
 */
`ifndef PTS_REGS_SVH
`define PTS_REGS_SVH

// Command codes of the read-only registers
`define PTS_CMD_VENDOR_STATUS  8'h80
`define PTS_CMD_VIN            8'h88
`define PTS_CMD_VOUT           8'h8b
`define PTS_CMD_IOUT           8'h8c
`define PTS_CMD_TEMP_INT       8'h8d
`define PTS_CMD_TEMP_EXT       8'h8f
`define PTS_CMD_DUTY           8'h94

// Vendor fault status bit positions
`define PTS_BIT_PHASE          6
`define PTS_BIT_DDC            4
`define PTS_BIT_SYNC           3
`define PTS_BIT_GROUP          2
`define PTS_BIT_STAGE          1
`define PTS_BIT_FAULT_BUS      0
`define PTS_VENDOR_RESET       8'h00
`define PTS_VENDOR_MASK        8'h5f

// Communication error status bit positions
`define PTS_CML_BIT_INVALID    7
`define PTS_CML_BIT_ACCESS     1
`define PTS_CML_RESET          8'h00

// Data lengths in bytes
`define PTS_LEN_STATUS         2'd1
`define PTS_LEN_TELEMETRY      2'd2

// Fixed exponents of the measurement words and the pin offset in mV
`define PTS_VOUT_EXP           -13
`define PTS_THERMAL_MONITOR_PIN_EXP           -3
`define PTS_THERMAL_MONITOR_PIN_OFFSET_MV     16'sd600
`define PTS_VIN_EXP            -6
`define PTS_IOUT_EXP           -4
`define PTS_TINT_EXP           -2
`define PTS_DUTY_EXP           -5

// Telemetry refresh period
`define PTS_CLK_MHZ            10
`define PTS_SAMPLE_PERIOD_US   100
`define PTS_SAMPLE_CYCLES      (`PTS_SAMPLE_PERIOD_US * `PTS_CLK_MHZ)

`endif

/* File: design/pts_pkg.sv */
/*
 * Types shared by the telemetry and vendor fault status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pts_pkg;

    // Command from the bus transaction layer
    typedef struct packed {
        logic       valid;   // One-cycle request strobe
        logic       write;   // Host tries to write
        logic [7:0] code;    // Command code
        logic [1:0] len;     // Bytes the host asks for
    } pts_cmd_t;

    // Asynchronous fault indications from pins
    typedef struct packed {
        logic phaseFail;       // Phase of sharing group failed
        logic ddcError;        // Inter-device bus error
        logic syncLost;        // External clock lost
        logic groupFault;      // Fault spread through group
        logic stageOverLimit;  // Thermal monitor pin above 2.5 V
        logic enableFaultBus;  // Shut down by enable pin
    } pts_fault_t;

    // Static configuration from the controller
    typedef struct packed {
        logic sharedRail;      // Part of a current sharing rail
        logic enableIsBus;     // Enable pin used as fault line
        logic tmonOtEnable;    // Thermal monitor used for over-temperature
    } pts_cfg_t;

    // Raw measurements from the converter logic
    typedef struct packed {
        logic signed [15:0] vin;     // Input voltage, fixed LSB
        logic        [15:0] vout;    // Output voltage, unsigned
        logic signed [15:0] iout;    // Output current, fixed LSB
        logic signed [15:0] tint;    // Internal temperature
        logic signed [15:0] tmonMv;  // Thermal monitor pin in mV
        logic signed [15:0] duty;    // Duty cycle, fixed LSB
        logic               pwmActive;
        logic               enabled;
    } pts_meas_t;

    // Read-out sequencer states, one-hot
    typedef enum logic [2:0] {
        PTS_IDLE = 3'b001,
        PTS_LOW  = 3'b010,
        PTS_HIGH = 3'b100
    } pts_state_t;

endpackage

/* File: design/pts_sync.sv */
/*
 * Two-flop synchroniser for a group of level inputs.
 * Assumes the inputs are levels that stay long enough to be seen.
 */
`timescale 1ns/1ps
module pts_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] metaQ;  // First stage, read only by second

    // Refuse an empty group
    if (WIDTH < 1) begin : gWidthCheck
        $error("pts_sync: WIDTH must be at least 1");
    end

    // Two stages, cleared at reset
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            metaQ <= '0;
            dout  <= '0;
        end else begin
            metaQ <= din;
            dout  <= metaQ;
        end
    end

endmodule

/* File: design/pts_linear11.sv */
/*
 * Packs a signed value with a fixed LSB exponent into a Linear-11 word.
 * Assumes the input LSB weight is two to the power EXP.
 */
`timescale 1ns/1ps
module pts_linear11 #(
    parameter int EXP = -4
) (
    input  wire logic signed [15:0] raw,
    output logic             [15:0] word
);

    // Exponent must leave room for the shifts below
    if (EXP < -16 || EXP > 10) begin : gExpCheck
        $error("pts_linear11: EXP out of range");
    end

    // Shift right until the mantissa fits eleven signed bits
    function automatic logic [15:0] pack(input logic signed [15:0] v);
        logic signed [15:0] m;
        logic        [4:0]  e;
        m = v;
        e = 5'(EXP);
        for (int i = 0; i < 5; i++) begin
            if (m > 16'sd1023 || m < -16'sd1024) begin
                m = m >>> 1;
                e = e + 5'd1;
            end
        end
        return {e, m[10:0]};
    endfunction

    assign word = pack(raw);

endmodule

/* File: testbench/pts_telemetry_status_assertions.sv */
/*
 * Checker for the telemetry and vendor fault status block: reply framing, refusals, fault flags and latch-off.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/1ps
`include "pts_regs.svh"
module pts_checker (
    input wire logic               ref_clk,
    input wire logic               arst_n,
    input wire pts_pkg::pts_cmd_t  cmd,
    input wire pts_pkg::pts_fault_t faultPins,
    input wire pts_pkg::pts_cfg_t  cfg,
    input wire logic               busy,
    input wire logic               rspValid,
    input wire logic               rspLast,
    input wire logic [7:0]         cmlStatus,
    input wire logic [7:0]         vendorStatus,
    input wire logic               shutdownLatched
);
    import pts_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic take;    // Command accepted this edge
    logic known;   // Code belongs to this register set
    logic isStat;  // Code is the fault byte
    logic goodRd;  // Legal read
    assign take   = cmd.valid && !busy;
    assign known  = cmd.code inside {`PTS_CMD_VENDOR_STATUS, `PTS_CMD_VIN, `PTS_CMD_VOUT, `PTS_CMD_IOUT,
                                     `PTS_CMD_TEMP_INT, `PTS_CMD_TEMP_EXT, `PTS_CMD_DUTY};
    assign isStat = cmd.code == `PTS_CMD_VENDOR_STATUS;
    assign goodRd = take && !cmd.write && known && (cmd.len == (isStat ? `PTS_LEN_STATUS : `PTS_LEN_TELEMETRY));
    a_unused_bits_zero: assert property (vendorStatus[7] == 1'b0 && vendorStatus[5] == 1'b0)
        else $error("unused fault bits set");
    a_status_one_byte: assert property (goodRd && isStat |-> ##2 rspValid && rspLast ##1 !rspValid)
        else $error("fault byte reply not one byte");
    a_telemetry_two_bytes: assert property (goodRd && !isStat |-> ##2 rspValid && !rspLast ##1 rspValid && rspLast)
        else $error("telemetry reply not two bytes");
    a_write_flagged: assert property (take && cmd.write && known |-> ##[1:2] cmlStatus[1])
        else $error("write to read-only not flagged");
    a_refused_silent: assert property (take && (cmd.write || !known) |=> !rspValid [*3])
        else $error("refused command answered");
    a_stage_flag_set: assert property (faultPins.stageOverLimit [*3] |-> ##[1:2] vendorStatus[1])
        else $error("power stage fault not flagged");
    a_ddc_flag_set: assert property (faultPins.ddcError [*3] |-> ##[1:2] vendorStatus[4])
        else $error("bus error not flagged");
    a_phase_needs_share: assert property ($rose(vendorStatus[6]) |-> cfg.sharedRail)
        else $error("phase flag without shared rail");
    a_bus_needs_enable: assert property ($rose(vendorStatus[0]) |-> cfg.enableIsBus)
        else $error("fault line flag without enable bus");
    a_shutdown_holds: assert property (shutdownLatched |=> shutdownLatched)
        else $error("latch-off released");
    a_stage_latches: assert property ((cfg.tmonOtEnable && faultPins.stageOverLimit) [*3] |-> ##[1:2] shutdownLatched)
        else $error("latch-off missing");
    // Main scenarios
    c_telemetry_read: cover property (goodRd && !isStat);
    c_write_refused: cover property (take && cmd.write);
    c_latch_off: cover property ($rose(shutdownLatched));
endmodule
bind pts_telemetry_status pts_checker i_chk (.ref_clk(ref_clk), .arst_n(arst_n), .cmd(cmd), .faultPins(faultPins),
    .cfg(cfg), .busy(busy), .rspValid(rspValid), .rspLast(rspLast), .cmlStatus(cmlStatus),
    .vendorStatus(vendorStatus), .shutdownLatched(shutdownLatched));

/* File: testbench/pts_host_model.sv */
/*
 * Host model: issues one command on the command port and collects the reply bytes.
 * Assumes it is called just after a rising edge and the block answers within six cycles.
 */
`timescale 1ns/1ps
module pts_host_model (
    input  wire logic         ref_clk,
    input  wire logic         busy,
    input  wire logic         rspValid,
    input  wire logic [7:0]   rspByte,
    output pts_pkg::pts_cmd_t cmd
);
    import pts_pkg::*;
    // Idle request at time zero
    initial cmd = '0;
    // One transfer; bytes gathered low first
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [1:0] len,
                        output logic [15:0] data, output int nb);
        int guard;
        data = 16'h0000;
        nb = 0;
        guard = 0;
        while (busy !== 1'b0 && guard < 20) begin
            @(posedge ref_clk);
            #1;
            guard++;
        end
        cmd = '{valid: 1'b1, write: wr, code: code, len: len};
        @(posedge ref_clk);
        #1;
        // Released lines show the inverse, not the old value
        cmd = '{valid: 1'b0, write: ~wr, code: ~code, len: ~len};
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            if (rspValid === 1'b1) begin
                if (nb < 2) data[nb*8 +: 8] = rspByte;
                nb++;
            end
        end
    endtask
endmodule

/* File: testbench/tb_pmbus_telemetry_status.sv */
/*
 * Testbench for the telemetry and vendor fault status block: reads, refusals, fault flags, latch-off.
 * Assumes the host model in its own file and a short refresh period of 8 cycles.
 */
`timescale 1ns/1ps
module tb_pmbus_telemetry_status;
    import pts_pkg::*;
    logic        refClk, arstN, clearFaults, busy, rspValid, rspLast, shutdownLatched;
    logic [7:0]  rspByte, cmlStatus, vendorStatus;
    pts_cmd_t    cmd;
    pts_fault_t  faultPins;
    pts_cfg_t    cfg;
    pts_meas_t   meas;
    int          miscompares, totalChecks, cycles;
    logic [15:0] d;
    int          n;
    pts_telemetry_status #(.SAMPLE_CYCLES(8)) i_dut (.ref_clk(refClk), .arst_n(arstN), .cmd(cmd),
        .clearFaults(clearFaults), .faultPins(faultPins), .cfg(cfg), .meas(meas), .busy(busy),
        .rspValid(rspValid), .rspByte(rspByte), .rspLast(rspLast), .cmlStatus(cmlStatus),
        .vendorStatus(vendorStatus), .shutdownLatched(shutdownLatched));
    pts_host_model i_host (.ref_clk(refClk), .busy(busy), .rspValid(rspValid), .rspByte(rspByte), .cmd(cmd));
    // Clock, 100 ns period
    initial begin
        refClk = 1'b0;
        forever #50 refClk = ~refClk;
    end
    // Hang guard
    always @(posedge refClk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Expected Linear-11 word from a raw value with LSB weight two^e
    function automatic logic [15:0] lin11(input int raw, input int e);
        int m;
        int x;
        m = raw;
        x = e;
        for (int k = 0; k < 5; k++) if (m > 1023 || m < -1024) begin
            m = m >>> 1;
            x++;
        end
        return {x[4:0], m[10:0]};
    endfunction
    task automatic tick(input int c);
        repeat (c) @(posedge refClk);
        #1;
    endtask
    task automatic rd_word(input logic [7:0] code, input logic [15:0] exp, input string nm);
        i_host.xfer(1'b0, code, 2'd2, d, n);
        check(nm, exp, d);
        check("reply bytes", 16'd2, 16'(n));
    endtask
    task automatic rd_stat(input logic [7:0] exp);
        i_host.xfer(1'b0, 8'h80, 2'd1, d, n);
        check("fault byte", {8'h00, exp}, d);
        check("fault byte count", 16'd1, 16'(n));
    endtask
    task automatic refuse(input logic wr, input logic [7:0] code, input logic [1:0] len, input logic [7:0] exp);
        i_host.xfer(wr, code, len, d, n);
        check("refused bytes", 16'd0, 16'(n));
        check("comm status", {8'h00, exp}, {8'h00, cmlStatus});
        clearFaults = 1'b1;
        tick(1);
        clearFaults = 1'b0;
        tick(1);
    endtask
    initial begin
        miscompares = 0;
        totalChecks = 0;
        cycles = 0;
        arstN = 1'b0;
        clearFaults = 1'b0;
        faultPins = '0;
        cfg = '{sharedRail: 1'b1, enableIsBus: 1'b1, tmonOtEnable: 1'b0};
        meas = '{vin: 16'sd768, vout: 16'h2000, iout: 16'sd3000, tint: -16'sd160, tmonMv: 16'sd1400,
                 duty: 16'sd800, pwmActive: 1'b1, enabled: 1'b1};
        tick(12);
        arstN = 1'b1;
        check("comm after reset", 16'h0000, {8'h00, cmlStatus});
        rd_stat(8'h00);
        tick(20);
        rd_word(8'h88, lin11(768, -6), "input voltage");
        rd_word(8'h8b, 16'h2000, "output voltage");
        rd_word(8'h8c, lin11(3000, -4), "output current");
        rd_word(8'h8d, lin11(-160, -2), "internal temp");
        rd_word(8'h8f, lin11(800, -3), "pin temp");
        rd_word(8'h94, lin11(800, -5), "duty cycle");
        // Unregulated and disabled: no reading
        meas.pwmActive = 1'b0;
        meas.enabled = 1'b0;
        tick(20);
        rd_word(8'h8c, 16'h0000, "current unregulated");
        rd_word(8'h94, 16'h0000, "duty disabled");
        refuse(1'b1, 8'h88, 2'd2, 8'h02);
        refuse(1'b1, 8'h80, 2'd1, 8'h02);
        refuse(1'b0, 8'h55, 2'd2, 8'h80);
        refuse(1'b0, 8'h88, 2'd1, 8'h02);
        // Each fault pin alone, then cleared
        for (int i = 0; i < 6; i++) begin
            faultPins = 6'(1 << i);
            tick(5);
            rd_stat((i == 5) ? 8'h40 : 8'(1 << i));
            faultPins = '0;
            // Let the synchroniser drain, else the clear loses to the set
            tick(3);
            clearFaults = 1'b1;
            tick(1);
            clearFaults = 1'b0;
            tick(2);
        end
        rd_stat(8'h00);
        check("no latch-off", 16'h0000, {15'h0000, shutdownLatched});
        cfg = '{sharedRail: 1'b0, enableIsBus: 1'b0, tmonOtEnable: 1'b1};
        faultPins = 6'h21;
        tick(5);
        rd_stat(8'h00);
        faultPins = 6'h02;
        tick(5);
        faultPins = '0;
        // Pin level still in the synchroniser for two edges
        tick(3);
        clearFaults = 1'b1;
        tick(1);
        clearFaults = 1'b0;
        tick(3);
        check("latch-off", 16'h0001, {15'h0000, shutdownLatched});
        rd_stat(8'h00);
        complete_run();
    end
endmodule
